// file: hw/cnsc_bank.sv
// Network configuration object bank of a CANopen motor-controller node.
// Assumes a master on mclk presents one-cycle object dictionary requests.
// Behaviour
// - Startup selector zero gives Pre-Operational; value eight gives Operational.
// - Bit-rate codes 0x81..0x86 and 0x88 map to 10..1000 kBd.
// - Any other bit-rate code selects 1000 kBd.
// - Boot-message config one: boot loader stays silent, firmware announces.
// - Boot-message config zero: boot loader and firmware both announce.
// - Node identifier is a byte object preset to 0x7F.
`include "cnsc_consts.svh"

module cnsc_bank (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  cnsc_pkg::cnsc_req_t       req,
    input  wire logic                 init_pulse,
    output cnsc_pkg::cnsc_rsp_t       rsp,
    output cnsc_pkg::cnsc_active_t    active
);
    import cnsc_pkg::*;

    logic [31:0]   startup_state_select_q;
    logic [7:0]    bit_rate_code_q;
    logic [31:0]   boot_message_config_q;
    logic [7:0]    node_identifier_q;
    logic          ack_q;
    logic          err_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_mux;
    logic          acc_req;
    logic          acc_err;
    logic          wr_startup;
    logic          wr_bitrate;
    logic          wr_bootmsg;
    logic          wr_nodeid;
    cnsc_nmt_t     nmt_state_q;
    cnsc_rate_t    bit_rate_q;
    logic [7:0]    node_id_q;
    logic          boot_loader_msg_q;
    logic          firmware_msg_q;
    cnsc_active_t  active_d;
    cnsc_rate_t    rate_dec;
    logic          hit_startup;
    logic          hit_bitrate;
    logic          hit_count;
    logic          hit_bootmsg;
    logic          hit_nodeid;
    logic          hit_any;

    cnsc_rate_decode u_rate (
        .code (bit_rate_code_q),
        .rate (rate_dec)
    );

    // Object address decode; plain variables need subindex zero.
    always_comb begin
        hit_startup = (req.index == `CNSC_IDX_STARTUP) && (req.subindex == `CNSC_SUB_NONE);
        hit_bitrate = (req.index == `CNSC_IDX_BITRATE) && (req.subindex == `CNSC_SUB_NONE);
        hit_count   = (req.index == `CNSC_IDX_CONFIG) && (req.subindex == `CNSC_SUB_COUNT);
        hit_bootmsg = (req.index == `CNSC_IDX_CONFIG) && (req.subindex == `CNSC_SUB_BOOTMSG);
        hit_nodeid  = (req.index == `CNSC_IDX_NODEID) && (req.subindex == `CNSC_SUB_NONE);
        hit_any     = hit_startup | hit_bitrate | hit_count | hit_bootmsg | hit_nodeid;
    end

    // Write strobes of the writable objects; the entry count takes no writes.
    always_comb begin
        wr_startup = req.wr && hit_startup;
        wr_bitrate = req.wr && hit_bitrate;
        wr_bootmsg = req.wr && hit_bootmsg;
        wr_nodeid  = req.wr && hit_nodeid;
    end

    // Startup selector storage.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            startup_state_select_q <= `CNSC_RST_STARTUP;
        end else if (wr_startup) begin
            startup_state_select_q <= req.wdata;
        end
    end

    // Bit-rate code storage.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bit_rate_code_q <= `CNSC_RST_BITRATE;
        end else if (wr_bitrate) begin
            bit_rate_code_q <= req.wdata[7:0];
        end
    end

    // Boot-message configuration storage.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            boot_message_config_q <= `CNSC_RST_BOOTMSG;
        end else if (wr_bootmsg) begin
            boot_message_config_q <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            node_identifier_q <= `CNSC_RST_NODEID;
        end else if (wr_nodeid) begin
            node_identifier_q <= req.wdata[7:0];
        end
    end

    // A request is refused when it addresses no object or writes the entry count.
    always_comb begin
        acc_req = req.wr | req.rd;
        acc_err = acc_req & (~hit_any | (req.wr & hit_count));
    end

    // Read data of the addressed object; writes and refused reads return zero.
    always_comb begin
        rdata_mux = `CNSC_ZERO32;
        if (req.rd) begin
            if (hit_startup) begin
                rdata_mux = startup_state_select_q;
            end
            if (hit_bitrate) begin
                rdata_mux = {`CNSC_ZERO24, bit_rate_code_q};
            end
            if (hit_count) begin
                rdata_mux = {`CNSC_ZERO24, `CNSC_RST_COUNT};
            end
            if (hit_bootmsg) begin
                rdata_mux = boot_message_config_q;
            end
            if (hit_nodeid) begin
                rdata_mux = {`CNSC_ZERO24, node_identifier_q};
            end
        end
    end

    // Acknowledge one cycle after each request, standing for one cycle only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc_req;
        end
    end

    // Refusal flag, standing beside its acknowledge.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            err_q <= 1'b0;
        end else begin
            err_q <= acc_err;
        end
    end

    // Read data, standing beside its acknowledge.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= `CNSC_ZERO32;
        end else begin
            rdata_q <= rdata_mux;
        end
    end

    // Settings that the next initialisation applies.
    always_comb begin
        if (startup_state_select_q == `CNSC_STARTUP_OPER) begin
            active_d.nmt_state = CNSC_NMT_OPER;
        end else begin
            active_d.nmt_state = CNSC_NMT_PREOP;
        end
        active_d.bit_rate = rate_dec;
        active_d.node_id  = node_identifier_q;
        active_d.boot_loader_msg = (boot_message_config_q != `CNSC_BOOTMSG_SUPPRESS);
        active_d.firmware_msg = 1'b1;
    end

    // Startup state latched at initialisation only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nmt_state_q <= CNSC_NMT_PREOP;
        end else if (init_pulse) begin
            nmt_state_q <= active_d.nmt_state;
        end
    end

    // Bit rate latched at initialisation only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bit_rate_q <= CNSC_RATE_1000K;
        end else if (init_pulse) begin
            bit_rate_q <= active_d.bit_rate;
        end
    end

    // Node identifier latched at initialisation only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            node_id_q <= `CNSC_RST_NODEID;
        end else if (init_pulse) begin
            node_id_q <= active_d.node_id;
        end
    end

    // Boot loader announcement latched at initialisation only.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            boot_loader_msg_q <= 1'b1;
        end else if (init_pulse) begin
            boot_loader_msg_q <= active_d.boot_loader_msg;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            firmware_msg_q <= 1'b1;
        end else if (init_pulse) begin
            firmware_msg_q <= active_d.firmware_msg;
        end
    end

    assign rsp    = '{ack_q, err_q, rdata_q};
    assign active = '{nmt_state_q, bit_rate_q, node_id_q, boot_loader_msg_q, firmware_msg_q};

endmodule : cnsc_bank

// file: hw/cnsc_rate_decode.sv
// Bit-rate code decoder of the node startup configuration bank.
// Assumes a code byte from logic on the same clock; purely combinational.
`include "cnsc_consts.svh"

module cnsc_rate_decode (
    input  wire logic [7:0]          code,
    output cnsc_pkg::cnsc_rate_t     rate
);
    import cnsc_pkg::*;

    always_comb begin
        case (code)
            `CNSC_CODE_10K:   rate = CNSC_RATE_10K;
            `CNSC_CODE_20K:   rate = CNSC_RATE_20K;
            `CNSC_CODE_50K:   rate = CNSC_RATE_50K;
            `CNSC_CODE_125K:  rate = CNSC_RATE_125K;
            `CNSC_CODE_250K:  rate = CNSC_RATE_250K;
            `CNSC_CODE_500K:  rate = CNSC_RATE_500K;
            `CNSC_CODE_1000K: rate = CNSC_RATE_1000K;
            default:          rate = CNSC_RATE_1000K;
        endcase
    end

endmodule : cnsc_rate_decode

// file: inc/cnsc_consts.svh
// Constants of the CANopen node startup configuration bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CNSC_CONSTS_SVH
`define CNSC_CONSTS_SVH

`define CNSC_IDX_STARTUP      16'h1f80
`define CNSC_IDX_BITRATE      16'h2005
`define CNSC_IDX_CONFIG       16'h2007
`define CNSC_IDX_NODEID       16'h2009
`define CNSC_SUB_COUNT        8'h00
`define CNSC_SUB_BOOTMSG      8'h01
`define CNSC_SUB_NONE         8'h00

`define CNSC_RST_STARTUP      32'h0000_0000
`define CNSC_RST_BITRATE      8'h88
`define CNSC_RST_COUNT        8'h01
`define CNSC_RST_BOOTMSG      32'h0000_0000
`define CNSC_RST_NODEID       8'h7f

`define CNSC_STARTUP_OPER     32'h0000_0008
`define CNSC_STARTUP_PREOP    32'h0000_0000
`define CNSC_BOOTMSG_SUPPRESS 32'h0000_0001
`define CNSC_BOOTMSG_BOTH     32'h0000_0000

`define CNSC_CODE_10K         8'h81
`define CNSC_CODE_20K         8'h82
`define CNSC_CODE_50K         8'h83
`define CNSC_CODE_125K        8'h84
`define CNSC_CODE_250K        8'h85
`define CNSC_CODE_500K        8'h86
`define CNSC_CODE_1000K       8'h88

`define CNSC_ZERO32           32'h0000_0000
`define CNSC_ZERO24           24'h00_0000

`endif

// file: inc/cnsc_pkg.sv
// Types of the CANopen node startup configuration bank.
// Assumes cnsc_consts.svh lies on the include path.
`include "cnsc_consts.svh"

package cnsc_pkg;

    // Decoded bit rate, one-hot.
    typedef enum logic [6:0] {
        CNSC_RATE_10K   = 7'b000_0001,
        CNSC_RATE_20K   = 7'b000_0010,
        CNSC_RATE_50K   = 7'b000_0100,
        CNSC_RATE_125K  = 7'b000_1000,
        CNSC_RATE_250K  = 7'b001_0000,
        CNSC_RATE_500K  = 7'b010_0000,
        CNSC_RATE_1000K = 7'b100_0000
    } cnsc_rate_t;

    // Network state entered after initialisation, one-hot.
    typedef enum logic [1:0] {
        CNSC_NMT_PREOP = 2'b01,
        CNSC_NMT_OPER  = 2'b10
    } cnsc_nmt_t;

    // Object dictionary access request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
    } cnsc_req_t;

    // Object dictionary access answer.
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } cnsc_rsp_t;

    // Settings applied at initialisation.
    typedef struct packed {
        cnsc_nmt_t  nmt_state;
        cnsc_rate_t bit_rate;
        logic [7:0] node_id;
        logic       boot_loader_msg;
        logic       firmware_msg;
    } cnsc_active_t;

endpackage : cnsc_pkg

// file: test/cnsc_bank_assertions.sv
// Checker of the node startup bank.
// Assumes a bind to cnsc_bank.
module cnsc_bank_assertions (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input cnsc_pkg::cnsc_req_t    req,
    input wire logic              init_pulse,
    input cnsc_pkg::cnsc_rsp_t    rsp,
    input cnsc_pkg::cnsc_active_t active
);
    import cnsc_pkg::*;
    logic [31:0] st_q, bm_q;
    logic [7:0] br_q, id_q;
    wire [23:0] key = {req.index, req.subindex};
    wire known = br_q inside {[8'h81:8'h86]};
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= 32'h0000_0000;
            bm_q <= 32'h0000_0000;
            br_q <= 8'h88;
            id_q <= 8'h7f;
        end else if (req.wr) begin
            if (key == 24'h1f_8000) st_q <= req.wdata;
            if (key == 24'h20_0701) bm_q <= req.wdata;
            if (key == 24'h20_0500) br_q <= req.wdata[7:0];
            if (key == 24'h20_0900) id_q <= req.wdata[7:0];
        end
    end
    sequence id_rd_s;
        req.rd && key == 24'h20_0900;
    endsequence
    chk_oper_state: assert property (init_pulse && st_q == 8 |=>
        active.nmt_state == CNSC_NMT_OPER) else $error("state");
    chk_preop_state: assert property (init_pulse && st_q != 8 |=>
        active.nmt_state == CNSC_NMT_PREOP) else $error("preop");
    chk_rate_code: assert property (init_pulse && known |=>
        active.bit_rate == 7'h01 << ($past(br_q) - 8'h81)) else $error("rate");
    chk_rate_fallback: assert property (init_pulse && !known |=>
        active.bit_rate == CNSC_RATE_1000K) else $error("fallback");
    chk_boot_quiet: assert property (init_pulse && bm_q == 1 |=>
        !active.boot_loader_msg && active.firmware_msg) else $error("quiet");
    chk_boot_both: assert property (init_pulse && bm_q != 1 |=>
        active.boot_loader_msg && active.firmware_msg) else $error("both");
    chk_id_read: assert property (id_rd_s |=>
        rsp.ack && rsp.rdata == {24'h00_0000, id_q}) else $error("node id");
    chk_active_hold: assert property (!init_pulse |=> $stable(active))
        else $error("hold");
endmodule : cnsc_bank_assertions
bind cnsc_bank cnsc_bank_assertions u_cnsc_bank_assertions (
    .mclk, .sys_rst, .req, .init_pulse, .rsp, .active);

// file: test/cnsc_master.sv
// Object dictionary master model for the startup bank.
// Assumes an answer on the edge after each one-cycle request.
module cnsc_master (
    input  wire logic           mclk,
    output cnsc_pkg::cnsc_req_t req,
    input  cnsc_pkg::cnsc_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    task automatic xfer(bit w, logic [23:0] k, logic [31:0] d,
                        output cnsc_pkg::cnsc_rsp_t r);
        @(posedge mclk);
        #1 req = '{w, !w, k[23:8], k[7:0], d};
        @(posedge mclk);
        #1 r = rsp;
        // Released fields turn inverse so stale values never look held.
        req = '{1'b0, 1'b0, ~k[23:8], ~k[7:0], ~d};
    endtask : xfer
endmodule : cnsc_master

// file: test/test_cnsc_bank.sv
// Self-checking bench of the node startup bank.
// Assumes the master model and checker compile first.
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch %0t compare %h %h", $time, a, b); end end
module test_cnsc_bank;
    timeunit 1ns;
    timeprecision 1ns;
    import cnsc_pkg::*;
    logic mclk = 0, sys_rst = 1, init_pulse = 0;
    cnsc_req_t req;
    cnsc_rsp_t rsp, r;
    cnsc_active_t active, exp_act;
    int unsigned m [int];
    int n_errors = 0, n_tests = 0;
    cnsc_bank u_cnsc_bank (.mclk, .sys_rst, .req, .init_pulse, .rsp, .active);
    cnsc_master u_cnsc_master (.mclk, .req, .rsp);
    initial forever #50 mclk = ~mclk;
    task automatic finish_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic acc(bit w, int k, logic [31:0] d);
        bit bad;
        bad = !m.exists(k) || (w && k == 24'h20_0700);
        u_cnsc_master.xfer(w, k[23:0], d, r);
        `CHECK(r, {1'b1, bad, w || bad ? 32'h0000_0000 : m[k]})
        `CHECK(active, exp_act)
        if (w && !bad)
            m[k] = k[15:8] == 8'h05 || k[15:8] == 8'h09 ? d[7:0] : d;
    endtask : acc
    task automatic init();
        int c;
        c = m[24'h20_0500];
        exp_act.nmt_state = m[24'h1f_8000] == 8 ? CNSC_NMT_OPER : CNSC_NMT_PREOP;
        exp_act.bit_rate = c inside {[8'h81:8'h86]} ? cnsc_rate_t'(1 << (c - 8'h81))
                           : CNSC_RATE_1000K;
        exp_act.node_id = 8'(m[24'h20_0900]);
        exp_act.boot_loader_msg = m[24'h20_0701] != 1;
        @(posedge mclk);
        #1 init_pulse = 1;
        @(posedge mclk);
        #1 init_pulse = 0;
        `CHECK(active, exp_act)
    endtask : init
    // Holds reset for five cycles and returns the model to the presets.
    task automatic reset_dut();
        sys_rst = 1;
        m = '{24'h1f_8000: 0, 24'h20_0500: 8'h88, 24'h20_0700: 1,
              24'h20_0701: 0, 24'h20_0900: 8'h7f};
        exp_act = '{CNSC_NMT_PREOP, CNSC_RATE_1000K, 8'h7f, 1'b1, 1'b1};
        repeat (5) @(posedge mclk);
        #1 sys_rst = 0;
        `CHECK(active, exp_act)
    endtask : reset_dut
    initial begin
        void'($urandom(32'hda53));
        repeat (2) begin
            reset_dut();
            foreach (m[k])
                acc(0, k, 0);
            init();
            for (int i = 0; i < 14; i++) begin
                acc(1, 24'h20_0500, i < 10 ? 8'h80 + i : $urandom);
                acc(1, 24'h1f_8000, i % 3 ? $urandom % 3 * 8 : 8);
                acc(1, 24'h20_0701, i % 2 ? 1 : $urandom % 4);
                acc(1, 24'h20_0900, $urandom);
                acc(i % 2, 24'h20_0700 + i % 3, $urandom);
                foreach (m[k])
                    acc(0, k, 0);
                init();
            end
        end
        finish_test();
    end
    initial begin
        #200_000;
        n_errors++;
        finish_test();
    end
endmodule : test_cnsc_bank
